// file: hdl/sdceg_regs.vh
// Constants of the comparator event guard: widths, flag layout, reset values.
// Assumes it is included by its bare name from the design files.
`ifndef SDCEG_REGS_VH
`define SDCEG_REGS_VH

// Channel count and field widths.
`define SDCEG_NCH        4
`define SDCEG_ACC_W      10
`define SDCEG_OSR_W      5
`define SDCEG_FLAG_W     9

// Flag register layout: over flags, then under flags, then data ack.
`define SDCEG_OVER_LSB   0
`define SDCEG_UNDER_LSB  4
`define SDCEG_ACK_BIT    8

// Reset values.
`define SDCEG_FLAG_RST   9'h000
`define SDCEG_EVT_RST    8'h00

// Comparator filter type codes.
`define SDCEG_FT_SINC1   1'b0
`define SDCEG_FT_SINC2   1'b1

// Windows that must complete after a settings change before a channel settles.
`define SDCEG_SETTLE_WIN 2'h2

`endif

// file: hdl/sdceg_cmp_chan.v
// One comparator channel: a sinc1 or sinc2 accumulator over the oversampling
// window, compared against the low and high thresholds at each window end.
// Assumes mod_edge is a one-cycle pulse on mclk per modulator clock rising edge.
`timescale 1ns/1ps
`default_nettype none
`include "sdceg_regs.vh"

module sdceg_cmp_chan
(
   input  wire                      mclk,        // System clock.
   input  wire                      rst_n,       // Asynchronous reset, active low.
   input  wire                      mod_edge,    // Modulator clock rising edge pulse.
   input  wire                      mod_bit,     // Synchronised modulator data bit.
   input  wire                      filt_type,   // Filter type, sinc1 or sinc2.
   input  wire [`SDCEG_OSR_W-1:0]   osr,         // Comparator oversampling ratio.
   input  wire [`SDCEG_ACC_W-1:0]   low_thr,     // Low threshold.
   input  wire [`SDCEG_ACC_W-1:0]   high_thr,    // High threshold.
   output reg                       over_evt,    // Pulse: result above high threshold.
   output reg                       under_evt,   // Pulse: result below low threshold.
   output reg                       win_done     // Pulse: a window has completed.
);

   reg  [`SDCEG_OSR_W-1:0] cnt_reg;
   reg  [`SDCEG_ACC_W-1:0] sum1_reg;
   reg  [`SDCEG_ACC_W-1:0] sum2_reg;
   wire [`SDCEG_ACC_W-1:0] sum1_next;
   wire [`SDCEG_ACC_W-1:0] sum2_next;
   wire [`SDCEG_ACC_W-1:0] result;
   wire                    last;

   // Running sums; the second stage integrates the first for sinc2.
   assign sum1_next = sum1_reg + {{(`SDCEG_ACC_W-1){1'b0}}, mod_bit};
   assign sum2_next = sum2_reg + sum1_next;
   assign result    = (filt_type == `SDCEG_FT_SINC2) ? sum2_next : sum1_next;
   // A ratio of zero behaves as one so the window always ends.
   assign last      = ({1'b0, cnt_reg} + 6'h01) >= {1'b0, osr};

   // Settings are not latched per window; a change mid-window compares a
   // partial sum against new thresholds, which is how spurious events arise.
   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_reg   <= 5'h00;
         sum1_reg  <= 10'h000;
         sum2_reg  <= 10'h000;
         over_evt  <= 1'b0;
         under_evt <= 1'b0;
         win_done  <= 1'b0;
      end
      else
      begin
         over_evt  <= 1'b0;
         under_evt <= 1'b0;
         win_done  <= 1'b0;
         if (mod_edge)
         begin
            if (last)
            begin
               cnt_reg   <= 5'h00;
               sum1_reg  <= 10'h000;
               sum2_reg  <= 10'h000;
               over_evt  <= (result > high_thr);
               under_evt <= (result < low_thr);
               win_done  <= 1'b1;
            end
            else
            begin
               cnt_reg  <= cnt_reg + 5'h01;
               sum1_reg <= sum1_next;
               sum2_reg <= sum2_next;
            end
         end
      end
   end

endmodule // sdceg_cmp_chan

`default_nettype wire

// file: hdl/sdceg_top.v
// Comparator event guard of the sigma-delta filter unit: four comparator
// channels, sticky interrupt flags, and routing of events to destinations.
// Assumes software drives enables, clears and settings on mclk; the modulator
// clock and data arrive on pins and are synchronised here.
//
// Notes on behaviour
// - Four channels, over and under flags each.
// - Run-time settings changes may yield spurious events.
// - Every comparator event goes to each enabled destination; the data ack only sets its flag.
// - Uncleared flags block further processor interrupts.
// - One spurious data ack may follow sync.
`timescale 1ns/1ps
`default_nettype none
`include "sdceg_regs.vh"

module sdceg_top
(
   input  wire                          mclk,                  // System clock, 10 MHz.
   input  wire                          rst_n,                 // Async reset, active low.
   input  wire                          modulator_clock,       // Modulator clock pin.
   input  wire [`SDCEG_NCH-1:0]         mod_data,              // Modulator data pins.
   input  wire [`SDCEG_NCH-1:0]         filt_type,             // Filter type per channel.
   input  wire [4*`SDCEG_OSR_W-1:0]     comparator_oversample_ratio, // Ratio per channel.
   input  wire [4*`SDCEG_ACC_W-1:0]     low_threshold,         // Low threshold per channel.
   input  wire [4*`SDCEG_ACC_W-1:0]     high_threshold,        // High threshold per channel.
   input  wire [`SDCEG_NCH-1:0]         over_value_irq_enable, // Over flag enables.
   input  wire [`SDCEG_NCH-1:0]         under_value_irq_enable,// Under flag enables.
   input  wire                          data_ack_irq_enable,   // Data ack flag enable.
   input  wire [`SDCEG_FLAG_W-1:0]      flag_clear,            // Clear pulses per flag.
   input  wire [2*`SDCEG_NCH-1:0]       cla_task_enable,       // Coprocessor routing.
   input  wire [2*`SDCEG_NCH-1:0]       pwm_trip_enable,       // PWM crossbar routing.
   input  wire [2*`SDCEG_NCH-1:0]       gpio_xbar_enable,      // GPIO crossbar routing.
   input  wire                          filter_sync_pulse,     // Filter reset pulse.
   input  wire                          data_ack_event,        // Data filter ready pulse.
   output reg  [`SDCEG_FLAG_W-1:0]      filter_irq_flag_reg,   // Sticky flag register.
   output reg                           cpu_irq,               // Combined request level.
   output reg                           cpu_irq_pulse,         // New interrupt pulse.
   output reg  [2*`SDCEG_NCH-1:0]       cla_task_evt,          // Coprocessor task pulses.
   output reg  [2*`SDCEG_NCH-1:0]       pwm_trip_evt,          // PWM crossbar pulses.
   output reg  [2*`SDCEG_NCH-1:0]       gpio_xbar_evt,         // GPIO crossbar pulses.
   output reg                           data_ack_unsettled,    // First ack after sync.
   output reg  [`SDCEG_NCH-1:0]         cmp_unsettled          // Settling after a change.
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations.

   reg                      mclk_s1_reg;
   reg                      mclk_s2_reg;
   reg                      mclk_d_reg;
   reg  [`SDCEG_NCH-1:0]    data_s1_reg;
   reg  [`SDCEG_NCH-1:0]    data_s2_reg;
   reg                      ack_wait_reg;
   wire                     mod_edge;
   wire [`SDCEG_NCH-1:0]    over_evt;
   wire [`SDCEG_NCH-1:0]    under_evt;
   wire [`SDCEG_NCH-1:0]    win_done;
   wire [2*`SDCEG_NCH-1:0]  cmp_evt;
   wire [`SDCEG_FLAG_W-1:0] flag_en;
   wire [`SDCEG_FLAG_W-1:0] flag_set;
   wire [`SDCEG_FLAG_W-1:0] filter_irq_flag_next;

   // Gates an event vector with its destination enable vector.
   function [2*`SDCEG_NCH-1:0] route;
      input [2*`SDCEG_NCH-1:0] evt;
      input [2*`SDCEG_NCH-1:0] en;
      begin
         route = evt & en;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and modulator clock edge detection.

   // Two flops per pin, plus a third on the modulator clock for edge detection; the first stage feeds no logic.
   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mclk_s1_reg <= 1'b0;
         mclk_s2_reg <= 1'b0;
         mclk_d_reg  <= 1'b0;
         data_s1_reg <= 4'h0;
         data_s2_reg <= 4'h0;
      end
      else
      begin
         mclk_s1_reg <= modulator_clock;
         mclk_s2_reg <= mclk_s1_reg;
         mclk_d_reg  <= mclk_s2_reg;
         data_s1_reg <= mod_data;
         data_s2_reg <= data_s1_reg;
      end
   end

   // The modulator clock must stay well below mclk/4 for edges to be seen.
   assign mod_edge = mclk_s2_reg & ~mclk_d_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Comparator channels and settings-change tracking.

   genvar ch;
   generate
      for (ch = 0; ch < `SDCEG_NCH; ch = ch + 1)
      begin : g_chan
         reg  [25:0] set_prev_reg;
         reg  [1:0]  settle_reg;
         wire [25:0] set_now;

         sdceg_cmp_chan u_chan
         (
            .mclk      (mclk),
            .rst_n     (rst_n),
            .mod_edge  (mod_edge),
            .mod_bit   (data_s2_reg[ch]),
            .filt_type (filt_type[ch]),
            .osr       (comparator_oversample_ratio[ch*`SDCEG_OSR_W +: `SDCEG_OSR_W]),
            .low_thr   (low_threshold[ch*`SDCEG_ACC_W +: `SDCEG_ACC_W]),
            .high_thr  (high_threshold[ch*`SDCEG_ACC_W +: `SDCEG_ACC_W]),
            .over_evt  (over_evt[ch]),
            .under_evt (under_evt[ch]),
            .win_done  (win_done[ch])
         );

         assign set_now = {filt_type[ch],
                           comparator_oversample_ratio[ch*`SDCEG_OSR_W +: `SDCEG_OSR_W],
                           low_threshold[ch*`SDCEG_ACC_W +: `SDCEG_ACC_W],
                           high_threshold[ch*`SDCEG_ACC_W +: `SDCEG_ACC_W]};

         // Status only: events are never suppressed while settling, so
         // software must keep its own disable and wait ordering.
         always @(posedge mclk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               set_prev_reg      <= 26'h0000000;
               settle_reg        <= 2'h0;
               cmp_unsettled[ch] <= 1'b0;
            end
            else
            begin
               set_prev_reg <= set_now;
               if (set_now != set_prev_reg)
               begin
                  settle_reg        <= `SDCEG_SETTLE_WIN;
                  cmp_unsettled[ch] <= 1'b1;
               end
               else if (win_done[ch] && (settle_reg != 2'h0))
               begin
                  settle_reg        <= settle_reg - 2'h1;
                  cmp_unsettled[ch] <= (settle_reg != 2'h1);
               end
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Flag register and processor interrupt.

   assign cmp_evt  = {under_evt, over_evt};
   assign flag_en  = {data_ack_irq_enable, under_value_irq_enable, over_value_irq_enable};
   // Only enabled events may raise a flag; the data ack takes the top bit.
   assign flag_set = {data_ack_event, cmp_evt} & flag_en;
   // A set arriving with its clear wins, so no event is lost.
   assign filter_irq_flag_next = (filter_irq_flag_reg & ~flag_clear) | flag_set;

   // The pulse fires only from an empty flag register; while any flag is
   // pending no further interrupt is raised until software clears it.
   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         filter_irq_flag_reg <= `SDCEG_FLAG_RST;
         cpu_irq             <= 1'b0;
         cpu_irq_pulse       <= 1'b0;
      end
      else
      begin
         filter_irq_flag_reg <= filter_irq_flag_next;
         cpu_irq             <= |filter_irq_flag_next;
         cpu_irq_pulse       <= (filter_irq_flag_reg == `SDCEG_FLAG_RST) &&
                                (flag_set != `SDCEG_FLAG_RST);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Routing to coprocessor and crossbars.

   // Crossbar paths ignore the interrupt enables; they have their own gates.
   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cla_task_evt  <= `SDCEG_EVT_RST;
         pwm_trip_evt  <= `SDCEG_EVT_RST;
         gpio_xbar_evt <= `SDCEG_EVT_RST;
      end
      else
      begin
         cla_task_evt  <= route(cmp_evt, cla_task_enable);
         pwm_trip_evt  <= route(cmp_evt, pwm_trip_enable);
         gpio_xbar_evt <= route(cmp_evt, gpio_xbar_enable);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Data acknowledge after a filter sync pulse.

   // The first ack after a sync pulse may come before the filter settles;
   // it is marked so the service routine can discard it.
   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ack_wait_reg       <= 1'b0;
         data_ack_unsettled <= 1'b0;
      end
      else
      begin
         data_ack_unsettled <= data_ack_event & ack_wait_reg;
         if (filter_sync_pulse)
         begin
            ack_wait_reg <= 1'b1;
         end
         else if (data_ack_event)
         begin
            ack_wait_reg <= 1'b0;
         end
      end
   end

endmodule // sdceg_top

`default_nettype wire

// file: testbench/sdceg_top_assertions.sv
// Checker of the comparator event guard: flags, request level and routing.
// Assumes it sees only top-level ports; it is bound at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
`include "sdceg_regs.vh"
module sdceg_top_assertions
(
   input wire logic        mclk,                   // System clock.
   input wire logic        rst_n,                  // Async reset, active low.
   input wire logic [3:0]  over_value_irq_enable,  // Over enables.
   input wire logic [3:0]  under_value_irq_enable, // Under enables.
   input wire logic        data_ack_irq_enable,    // Ack enable.
   input wire logic [8:0]  flag_clear,             // Clear pulses.
   input wire logic [7:0]  cla_task_enable,        // Coprocessor routing.
   input wire logic [7:0]  pwm_trip_enable,        // Trip routing.
   input wire logic        filter_sync_pulse,      // Sync pulse.
   input wire logic        data_ack_event,         // Ack pulse.
   input wire logic [8:0]  filter_irq_flag_reg,    // Sticky flags.
   input wire logic        cpu_irq,                // Request level.
   input wire logic        cpu_irq_pulse,          // New request pulse.
   input wire logic [7:0]  cla_task_evt,           // Coprocessor pulses.
   input wire logic [7:0]  pwm_trip_evt,           // Trip pulses.
   input wire logic        data_ack_unsettled      // First ack mark.
);
   logic [1:0] ack_marks_reg; // Marked acks since the last sync pulse.
   ////////////////////////////////////////
   // Saturating count, so a second mark after one sync cannot wrap away.
   always @(posedge mclk or negedge rst_n)
      if (!rst_n) ack_marks_reg <= 2'h0;
      else if (filter_sync_pulse) ack_marks_reg <= 2'h0;
      else if (data_ack_unsettled && ack_marks_reg != 2'h3) ack_marks_reg <= ack_marks_reg + 2'h1;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   property p_irq_level; cpu_irq == (|filter_irq_flag_reg); endproperty
   a_irq_level: assert property (p_irq_level) else $error("request level wrong");
   property p_sticky;
      1'b1 |=> ((~filter_irq_flag_reg & $past(filter_irq_flag_reg) & ~$past(flag_clear)) == 9'h000);
   endproperty
   a_sticky: assert property (p_sticky) else $error("flag fell without clear");
   property p_pulse_src; cpu_irq_pulse |-> cpu_irq && $past(filter_irq_flag_reg) == 9'h000; endproperty
   a_pulse_src: assert property (p_pulse_src) else $error("pulse while pending");
   property p_pulse_new; $rose(cpu_irq) |-> cpu_irq_pulse; endproperty
   a_pulse_new: assert property (p_pulse_new) else $error("no pulse on new request");
   property p_set_gate;
      ((filter_irq_flag_reg & ~$past(filter_irq_flag_reg)) & ~({data_ack_irq_enable,
         under_value_irq_enable, over_value_irq_enable} | $past({data_ack_irq_enable,
         under_value_irq_enable, over_value_irq_enable}))) == 9'h000;
   endproperty
   a_set_gate: assert property (p_set_gate) else $error("disabled flag set");
   property p_route_agree; ((cla_task_evt ^ pwm_trip_evt) & cla_task_enable & pwm_trip_enable) == 8'h00; endproperty
   a_route_agree: assert property (p_route_agree) else $error("routes disagree");
   property p_route_pulse; pwm_trip_evt != 8'h00 |=> (pwm_trip_evt & $past(pwm_trip_evt)) == 8'h00; endproperty
   a_route_pulse: assert property (p_route_pulse) else $error("trip pulse too long");
   property p_ack_cause; data_ack_unsettled |-> $past(data_ack_event); endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("mark without ack");
   property p_ack_once; ack_marks_reg < 2'h2; endproperty
   a_ack_once: assert property (p_ack_once) else $error("two marks after one sync");
endmodule // sdceg_top_assertions
bind sdceg_top sdceg_top_assertions u_sdceg_top_assertions
(
   .mclk(mclk), .rst_n(rst_n), .over_value_irq_enable(over_value_irq_enable),
   .under_value_irq_enable(under_value_irq_enable), .data_ack_irq_enable(data_ack_irq_enable),
   .flag_clear(flag_clear), .cla_task_enable(cla_task_enable), .pwm_trip_enable(pwm_trip_enable),
   .filter_sync_pulse(filter_sync_pulse), .data_ack_event(data_ack_event),
   .filter_irq_flag_reg(filter_irq_flag_reg), .cpu_irq(cpu_irq), .cpu_irq_pulse(cpu_irq_pulse),
   .cla_task_evt(cla_task_evt), .pwm_trip_evt(pwm_trip_evt), .data_ack_unsettled(data_ack_unsettled)
);
`default_nettype wire

// file: testbench/sdceg_mod_model.sv
// Modulator model: 800 ns clock and one constant bit level per channel.
// Assumes the bench raises run for a frame; the clock stands still otherwise.
`timescale 1ns/1ps
`default_nettype none
module sdceg_mod_model
(
   input  wire logic       run,             // Frame active.
   input  wire logic [3:0] ones,            // Bit level per channel in a frame.
   output var  logic       modulator_clock, // Modulator clock pin.
   output var  logic [3:0] mod_data         // Bitstream per channel.
);
   initial modulator_clock = 1'b0;
   initial mod_data = 4'h0;
   // Data moves on the falling edge; outside a frame it keeps toggling
   // so a stale level can never look valid.
   always
   begin
      #400;
      if (run)
      begin
         modulator_clock = ~modulator_clock;
         if (!modulator_clock) mod_data = ones;
      end
      else
      begin
         modulator_clock = 1'b0;
         mod_data = ~mod_data;
      end
   end
endmodule // sdceg_mod_model
`default_nettype wire

// file: testbench/sdceg_top_tb.sv
// Testbench of the comparator event guard: settings, enables, clears, sync.
// Assumes the modulator model on the pins and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module sdceg_top_tb;
   logic        mclk = 1'b0, rst_n = 1'b0, run = 1'b0, ack_en = 1'b0, sync = 1'b0, ack = 1'b0;
   logic        modulator_clock, irq, irq_p, ack_uns;
   logic [3:0]  ones = 4'hd, filt = 4'h4, ovr_en = 4'h0, und_en = 4'h0, mod_data, unset;
   logic [19:0] ratio = {4{5'h05}}; // Ratio five on every channel.
   logic [39:0] lo = {10'h000, 10'h000, 10'h002, 10'h000};
   logic [39:0] hi = {10'h005, 10'h00c, 10'h3ff, 10'h003};
   logic [8:0]  fclr = 9'h000, flags;
   logic [7:0]  cla_en = 8'h00, pwm_en = 8'h00, gpio_en = 8'h00, cla_evt, pwm_evt, gpio_evt;
   logic [7:0]  s_cla = 8'h00, s_pwm = 8'h00, s_gpio = 8'h00;
   int          n_fail = 0, checks_done = 0, n_pulse = 0, n_unset = 0, cyc = 0;
   sdceg_top u_sdceg_top
   (
      .mclk(mclk), .rst_n(rst_n), .modulator_clock(modulator_clock), .mod_data(mod_data),
      .filt_type(filt), .comparator_oversample_ratio(ratio), .low_threshold(lo),
      .high_threshold(hi), .over_value_irq_enable(ovr_en), .under_value_irq_enable(und_en),
      .data_ack_irq_enable(ack_en), .flag_clear(fclr), .cla_task_enable(cla_en),
      .pwm_trip_enable(pwm_en), .gpio_xbar_enable(gpio_en), .filter_sync_pulse(sync),
      .data_ack_event(ack), .filter_irq_flag_reg(flags), .cpu_irq(irq), .cpu_irq_pulse(irq_p),
      .cla_task_evt(cla_evt), .pwm_trip_evt(pwm_evt), .gpio_xbar_evt(gpio_evt),
      .data_ack_unsettled(ack_uns), .cmp_unsettled(unset)
   );
   sdceg_mod_model u_sdceg_mod_model
   (
      .run(run), .ones(ones), .modulator_clock(modulator_clock), .mod_data(mod_data)
   );
   ////////////////////////////////////////
   // Compares one value, counts it and reports a mismatch at once.
   task automatic chk(input string name, input logic [8:0] seen, input logic [8:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic stop_test;
      if (n_fail == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Waits n edges and lets their updates land before sampling.
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   always #50 mclk = ~mclk;
   // Gathers pulses over the run; the ceiling cuts a hang short.
   always @(posedge mclk)
   begin
      cyc <= cyc + 1;
      // Unknown outputs before the first reset edge must not poison the sums.
      s_cla <= rst_n ? (s_cla | cla_evt) : 8'h00;
      s_pwm <= rst_n ? (s_pwm | pwm_evt) : 8'h00;
      s_gpio <= rst_n ? (s_gpio | gpio_evt) : 8'h00;
      n_pulse <= n_pulse + int'(irq_p);
      n_unset <= n_unset + int'(ack_uns);
      if (cyc == 3000)
      begin
         n_fail++;
         stop_test;
      end
   end
   initial
   begin
      tick(2);
      @(posedge mclk) rst_n <= 1'b1;
      tick(1);
      chk("flags", flags, 9'h000);
      @(posedge mclk) run <= 1'b1;
      tick(100); // Filter latency within twelve and a half modulator clocks first.
      @(posedge mclk)
      begin
         ovr_en <= 4'hf;
         und_en <= 4'hf;
         cla_en <= 8'hff;
         pwm_en <= 8'h01;
         gpio_en <= 8'h20;
      end
      tick(120);
      chk("flags", flags, 9'h025);
      chk("irq", {8'h00, irq}, 9'h001);
      chk("cla", {1'b0, s_cla}, 9'h025);
      chk("pwm", {1'b0, s_pwm}, 9'h001);
      chk("gpio", {1'b0, s_gpio}, 9'h020);
      chk("pulses", n_pulse[8:0], 9'h001);
      // Disable before touching anything, then clear.
      @(posedge mclk) {ovr_en, und_en, cla_en, pwm_en, gpio_en} <= 32'h0;
      tick(4);
      @(posedge mclk) fclr <= 9'h1ff;
      @(posedge mclk) fclr <= 9'h000;
      @(posedge mclk) hi[39:30] <= 10'h004; // Run-time change while disabled.
      tick(1);
      chk("unsettled", {5'h00, unset}, 9'h008);
      tick(99);
      chk("unsettled", {5'h00, unset}, 9'h000);
      chk("flags", flags, 9'h000);
      chk("irq", {8'h00, irq}, 9'h000);
      @(posedge mclk) ovr_en <= 4'h8;
      tick(100);
      chk("flags", flags, 9'h008);
      chk("pulses", n_pulse[8:0], 9'h002);
      // Sync, then two acks: only the first one is marked.
      @(posedge mclk) ack_en <= 1'b1;
      @(posedge mclk) sync <= 1'b1;
      @(posedge mclk) sync <= 1'b0;
      tick(3);
      @(posedge mclk) ack <= 1'b1;
      @(posedge mclk) ack <= 1'b0;
      // The routine clears the spurious ack flag no sooner than 1.2 us after sync.
      tick(12);
      @(posedge mclk) fclr <= 9'h100; // One sample within the count, so clear.
      @(posedge mclk) fclr <= 9'h000;
      tick(1);
      chk("flags", flags, 9'h008);
      @(posedge mclk) ack <= 1'b1;
      @(posedge mclk) ack <= 1'b0;
      tick(5);
      chk("flags", flags, 9'h108);
      chk("marks", n_unset[8:0], 9'h001);
      chk("pulses", n_pulse[8:0], 9'h002);
      stop_test;
   end
endmodule // sdceg_top_tb
`default_nettype wire
